// ==== rtl/sre_pkg.sv ====
// Package: register map, field positions and reset values of the receive error block
package sre_pkg;

	// ==========================================================
	// Register bus geometry
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;

	// ==========================================================
	// Offsets, normal map
	localparam logic [2:0] OFF_BAUD_HIGH    = 3'h0;
	localparam logic [2:0] OFF_BAUD_LOW     = 3'h1;
	localparam logic [2:0] OFF_CONTROL      = 3'h2;
	// Offsets, alternative map
	localparam logic [2:0] OFF_IRQ_STATUS   = 3'h0;
	localparam logic [2:0] OFF_ALT_CONTROL  = 3'h1;
	// Offsets present in both maps
	localparam logic [2:0] OFF_RX_STATUS    = 3'h4;
	localparam logic [2:0] OFF_MAP_CONTROL  = 3'h5;
	localparam logic [2:0] OFF_RX_DATA_LOW  = 3'h7;

	// ==========================================================
	// Field positions
	localparam int BIT_EDGE        = 7;
	localparam int BIT_BIT_ERROR   = 1;
	localparam int BIT_BREAK       = 0;
	localparam int BIT_RX_FULL     = 5;
	localparam int BIT_OVERRUN     = 3;
	localparam int BIT_NOISE       = 2;
	localparam int BIT_FRAMING     = 1;
	localparam int BIT_PARITY_ERR  = 0;
	localparam int BIT_RX_ENABLE   = 2;
	localparam int BIT_PARITY_EN   = 1;
	localparam int BIT_PARITY_TYPE = 0;
	localparam int BIT_ALT_MAP     = 7;

	// ==========================================================
	// Reset values and counts
	localparam logic [7:0]  RST_ALT_CONTROL = 8'h00;
	localparam logic [7:0]  RST_CONTROL     = 8'h00;
	localparam logic [12:0] RST_BAUD        = 13'h0004;
	localparam logic [3:0]  OVERSAMPLE_LAST = 4'hf;
	localparam logic [3:0]  SAMPLE_A        = 4'h7;
	localparam logic [3:0]  SAMPLE_B        = 4'h8;
	localparam logic [3:0]  SAMPLE_C        = 4'h9;
	localparam logic [2:0]  DATA_BITS_LAST  = 3'h7;

	// ==========================================================
	// Receiver states
	typedef enum logic [2:0] {
		SRE_IDLE,
		SRE_START,
		SRE_DATA,
		SRE_PARITY,
		SRE_STOP
	} sre_state_t;

endpackage : sre_pkg

// ==== rtl/sre_receive_error_flags.sv ====
// Module: serial receiver with error flags, alternative interrupt enables and register port
`timescale 1ns/1ps
`default_nettype none

//Function
// - Alternative control reachable only with alternative map
// - Bit 7 enables edge flag interrupt
// - Bit 1 enables bit-error flag interrupt
// - Bit 0 enables break flag interrupt
// - Overrun set when frame ends while full
// - Overrun frame discarded, data register kept
// - Status read then data read clears overrun
// - Noise flag set with full, never overrun
// - Zero stop bit sets framing error flag
// - Framing error blocks reception until cleared
// - Parity mismatch sets parity error when enabled
// - Status read then data read clears noise, parity
module sre_receive_error_flags
	import sre_pkg::*;
(
	input  wire logic              SYS_CLK,
	input  wire logic              RESETN,
	input  wire logic [ADDR_W-1:0] ADDR,
	input  wire logic [DATA_W-1:0] WDATA,
	input  wire logic              WR,
	input  wire logic              RD,
	output logic      [DATA_W-1:0] RDATA,
	input  wire logic              RX_PIN,
	input  wire logic              BIT_ERROR_EVENT,
	output logic                   IRQ
);

	// ==========================================================
	// Registers
	logic [7:0]  alt_control_one;
	logic [7:0]  control;
	logic [12:0] baud;
	logic        alt_map_select;
	logic [7:0]  irq_status;
	logic [7:0]  rx_data_low;
	logic        receive_full_flag;
	logic        overrun_flag;
	logic        noise_flag;
	logic        framing_error_flag;
	logic        parity_error_flag;
	logic [4:0]  clear_armed;

	// ==========================================================
	// Receiver state
	logic [2:0]  rx_sync;
	logic        rx_level;
	logic        rx_level_d;
	sre_state_t  state;
	logic [12:0] baud_count;
	logic        tick;
	logic [3:0]  phase;
	logic [2:0]  bit_index;
	logic [7:0]  shift;
	logic [2:0]  votes;
	logic        frame_noise;
	logic        parity_bit;
	logic        voted;
	logic        disagree;
	logic        frame_done;
	logic        stop_ok;
	logic        parity_bad;
	logic        break_seen;
	logic        edge_event;

	logic        parity_enable;
	logic        parity_type;
	logic        rx_enable;
	logic [7:0]  receive_status_one;
	logic        rd_status;
	logic        rd_data;
	logic        rd_irq_status;
	logic        alt_hit;
	logic [7:0]  next_rdata;

	assign parity_enable = control[BIT_PARITY_EN];
	assign parity_type   = control[BIT_PARITY_TYPE];
	assign rx_enable     = control[BIT_RX_ENABLE];

	assign alt_hit       = alt_map_select && (ADDR == OFF_ALT_CONTROL);
	assign rd_status     = RD && (ADDR == OFF_RX_STATUS);
	assign rd_data       = RD && (ADDR == OFF_RX_DATA_LOW);
	assign rd_irq_status = RD && alt_map_select && (ADDR == OFF_IRQ_STATUS);

	// ==========================================================
	// Pin synchroniser: a change counts once stages two and three agree
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			rx_sync <= 3'h7;
		end else begin
			rx_sync <= {rx_sync[1:0], RX_PIN};
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			rx_level   <= 1'b1;
			rx_level_d <= 1'b1;
		end else begin
			if (rx_sync[1] == rx_sync[2]) begin
				rx_level <= rx_sync[2];
			end
			rx_level_d <= rx_level;
		end
	end

	assign edge_event = rx_level_d && !rx_level;

	// ==========================================================
	// Oversampling tick: sixteen ticks per bit
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			baud_count <= 13'h0000;
			tick       <= 1'b0;
		end else if (baud_count >= baud - 13'h0001) begin
			baud_count <= 13'h0000;
			tick       <= 1'b1;
		end else begin
			baud_count <= baud_count + 13'h0001;
			tick       <= 1'b0;
		end
	end

	// ==========================================================
	// Receive sequencer with majority vote over three samples
	assign voted    = (votes[0] & votes[1]) | (votes[1] & votes[2]) | (votes[0] & votes[2]);
	assign disagree = !((votes == 3'h0) || (votes == 3'h7));

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			state       <= SRE_IDLE;
			phase       <= 4'h0;
			bit_index   <= 3'h0;
			shift       <= 8'h00;
			votes       <= 3'h0;
			frame_noise <= 1'b0;
			parity_bit  <= 1'b0;
			frame_done  <= 1'b0;
			stop_ok     <= 1'b0;
		end else begin
			frame_done <= 1'b0;
			if (tick) begin
				phase <= phase + 4'h1;
				if (phase == SAMPLE_A) begin
					votes[0] <= rx_level;
				end
				if (phase == SAMPLE_B) begin
					votes[1] <= rx_level;
				end
				if (phase == SAMPLE_C) begin
					votes[2] <= rx_level;
				end
			end
			case (state)
				SRE_IDLE: begin
					// Framing error holds the receiver off
					if (edge_event && rx_enable && !framing_error_flag) begin
						state       <= SRE_START;
						phase       <= 4'h0;
						frame_noise <= 1'b0;
					end
				end
				SRE_START: begin
					if (tick && phase == OVERSAMPLE_LAST) begin
						if (voted) begin
							state <= SRE_IDLE;
						end else begin
							state       <= SRE_DATA;
							bit_index   <= 3'h0;
							frame_noise <= disagree;
						end
					end
				end
				SRE_DATA: begin
					if (tick && phase == OVERSAMPLE_LAST) begin
						shift       <= {voted, shift[7:1]};
						frame_noise <= frame_noise | disagree;
						bit_index   <= bit_index + 3'h1;
						if (bit_index == DATA_BITS_LAST) begin
							state <= parity_enable ? SRE_PARITY : SRE_STOP;
						end
					end
				end
				SRE_PARITY: begin
					if (tick && phase == OVERSAMPLE_LAST) begin
						parity_bit  <= voted;
						frame_noise <= frame_noise | disagree;
						state       <= SRE_STOP;
					end
				end
				SRE_STOP: begin
					// Stop bit is judged at its middle samples
					if (tick && phase == SAMPLE_C) begin
						stop_ok     <= rx_level & votes[1] & votes[0];
						frame_noise <= frame_noise | !((votes[0] == votes[1]) && (votes[1] == rx_level));
						frame_done  <= 1'b1;
						state       <= SRE_IDLE;
					end
				end
				default: begin
					state <= SRE_IDLE;
				end
			endcase
		end
	end

	// Even parity type 0: parity bit makes the ones count even
	assign parity_bad = parity_enable && ((^shift ^ parity_bit) != parity_type);
	assign break_seen = frame_done && !stop_ok && (shift == 8'h00) && !(parity_enable && parity_bit);

	// ==========================================================
	// Clear sequence: status read arms, data-low read clears armed flags
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			clear_armed <= 5'h00;
		end else if (rd_status) begin
			clear_armed <= {receive_full_flag, overrun_flag, noise_flag,
			                framing_error_flag, parity_error_flag};
		end else if (rd_data) begin
			clear_armed <= 5'h00;
		end
	end

	// ==========================================================
	// Receive flags and data; a new event wins over a clear
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			receive_full_flag  <= 1'b0;
			overrun_flag       <= 1'b0;
			noise_flag         <= 1'b0;
			framing_error_flag <= 1'b0;
			parity_error_flag  <= 1'b0;
			rx_data_low        <= 8'h00;
		end else begin
			if (rd_data) begin
				if (clear_armed[4]) begin
					receive_full_flag <= 1'b0;
				end
				if (clear_armed[3]) begin
					overrun_flag <= 1'b0;
				end
				if (clear_armed[2]) begin
					noise_flag <= 1'b0;
				end
				if (clear_armed[1]) begin
					framing_error_flag <= 1'b0;
				end
				if (clear_armed[0]) begin
					parity_error_flag <= 1'b0;
				end
			end
			if (frame_done) begin
				if (receive_full_flag || overrun_flag) begin
					// Shift register is dropped, held data stays
					overrun_flag <= 1'b1;
				end else begin
					rx_data_low        <= shift;
					receive_full_flag  <= 1'b1;
					noise_flag         <= frame_noise;
					framing_error_flag <= !stop_ok;
					parity_error_flag  <= parity_bad;
				end
			end
		end
	end

	assign receive_status_one = {2'h0, receive_full_flag, 1'b0, overrun_flag, noise_flag,
	                             framing_error_flag, parity_error_flag};

	// ==========================================================
	// Software-written registers
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			alt_control_one <= RST_ALT_CONTROL;
		end else if (WR && alt_hit) begin
			alt_control_one <= WDATA & 8'h83;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			control        <= RST_CONTROL;
			baud           <= RST_BAUD;
			alt_map_select <= 1'b0;
		end else if (WR) begin
			if (ADDR == OFF_MAP_CONTROL) begin
				alt_map_select <= WDATA[BIT_ALT_MAP];
			end
			if (!alt_map_select) begin
				if (ADDR == OFF_BAUD_HIGH) begin
					baud[12:8] <= WDATA[4:0];
				end
				if (ADDR == OFF_BAUD_LOW) begin
					baud[7:0] <= WDATA;
				end
				if (ADDR == OFF_CONTROL) begin
					control <= WDATA & 8'h07;
				end
			end
		end
	end

	// ==========================================================
	// Interrupt status: sticky, cleared by a read, set wins
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			irq_status <= 8'h00;
		end else begin
			irq_status[BIT_EDGE]      <= edge_event || (irq_status[BIT_EDGE] && !rd_irq_status);
			irq_status[BIT_BIT_ERROR] <= BIT_ERROR_EVENT
			                             || (irq_status[BIT_BIT_ERROR] && !rd_irq_status);
			irq_status[BIT_BREAK]     <= break_seen || (irq_status[BIT_BREAK] && !rd_irq_status);
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= (irq_status[BIT_EDGE] && alt_control_one[BIT_EDGE])
			    || (irq_status[BIT_BIT_ERROR] && alt_control_one[BIT_BIT_ERROR])
			    || (irq_status[BIT_BREAK] && alt_control_one[BIT_BREAK]);
		end
	end

	// ==========================================================
	// Read port: data in the cycle after the strobe
	always_comb begin
		next_rdata = 8'h00;
		if (ADDR == OFF_RX_STATUS) begin
			next_rdata = receive_status_one;
		end else if (ADDR == OFF_MAP_CONTROL) begin
			next_rdata = {alt_map_select, 7'h00};
		end else if (ADDR == OFF_RX_DATA_LOW) begin
			next_rdata = rx_data_low;
		end else if (alt_map_select) begin
			if (ADDR == OFF_ALT_CONTROL) begin
				next_rdata = alt_control_one;
			end else if (ADDR == OFF_IRQ_STATUS) begin
				next_rdata = irq_status;
			end
		end else if (ADDR == OFF_BAUD_HIGH) begin
			next_rdata = {3'h0, baud[12:8]};
		end else if (ADDR == OFF_BAUD_LOW) begin
			next_rdata = baud[7:0];
		end else if (ADDR == OFF_CONTROL) begin
			next_rdata = control;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			RDATA <= 8'h00;
		end else if (RD) begin
			RDATA <= next_rdata;
		end else begin
			RDATA <= 8'h00;
		end
	end

endmodule : sre_receive_error_flags

`default_nettype wire

// ==== tb/sre_chk.sv ====
// Port-level checker of the receive error flag block
`timescale 1ns/1ps
`default_nettype none
module sre_chk
	import sre_pkg::*;
(
	input wire logic              SYS_CLK,
	input wire logic              RESETN,
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [DATA_W-1:0] WDATA,
	input wire logic              WR,
	input wire logic              RD,
	input wire logic [DATA_W-1:0] RDATA,
	input wire logic              RX_PIN,
	input wire logic              BIT_ERROR_EVENT,
	input wire logic              IRQ
);
	// ==========================================
	// Shadow of map select and interrupt enables
	logic       map;
	logic [7:0] alt;
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			map <= 1'b0;
		end else if (WR && ADDR == OFF_MAP_CONTROL) begin
			map <= WDATA[BIT_ALT_MAP];
		end
	end
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			alt <= 8'h00;
		end else if (WR && ADDR == OFF_ALT_CONTROL && map) begin
			alt <= WDATA & 8'h83;
		end
	end
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);
	reset_clear_a: assert property (disable iff (1'b0) !RESETN |=> !IRQ && RDATA == 8'h00)
		else $error("outputs not cleared by reset");
	rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("read data outside read cycle");
	alt_read_a: assert property (RD && ADDR == OFF_ALT_CONTROL && map |=> RDATA == alt)
		else $error("alternative control read mismatch");
	unmapped_zero_a: assert property (RD && (ADDR == 3'h3 || ADDR == 3'h6) |=> RDATA == 8'h00)
		else $error("unmapped offset read not zero");
	control_mask_a: assert property (RD && ADDR == OFF_CONTROL && !map |=> RDATA[7:3] == 5'h00)
		else $error("control read has stray bits");
	flags_need_full_a: assert property (RD && ADDR == OFF_RX_STATUS |=>
		RDATA[7:6] == 2'h0 && !RDATA[4] && !(!RDATA[5] && RDATA[2:0] != 3'h0))
		else $error("error flag without receive full");
	bit_err_irq_a: assert property (BIT_ERROR_EVENT && alt[1] |-> ##[1:3] IRQ)
		else $error("enabled bit error gave no interrupt");
	irq_masked_a: assert property ((alt == 8'h00) [*3] |-> !IRQ)
		else $error("interrupt with all enables clear");
	irq_clear_a: assert property ($fell(IRQ) |-> $past(RD, 2) || $past(WR, 2))
		else $error("interrupt dropped without access");
endmodule : sre_chk
bind sre_receive_error_flags sre_chk sre_chk_i (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RX_PIN(RX_PIN),
	.BIT_ERROR_EVENT(BIT_ERROR_EVENT), .IRQ(IRQ));
`default_nettype wire

// ==== tb/sre_tx.sv ====
// Remote serial transmitter model on the receive line
`timescale 1ns/1ps
`default_nettype none
module sre_tx #(
	parameter int BIT_CLKS = 64
) (
	input  wire logic clk,
	output logic      line
);
	initial line = 1'b1;
	// Start bit, n bits LSB first, one idle bit; glitch hits mid first bit
	task automatic send(input logic [9:0] bits, input int n, input logic glitch);
		line <= 1'b0;
		repeat (BIT_CLKS) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			line <= bits[i];
			if (i == 0 && glitch) begin
				repeat (BIT_CLKS / 2 - 2) @(posedge clk);
				line <= ~bits[i];
				repeat (4) @(posedge clk);
				line <= bits[i];
				repeat (BIT_CLKS / 2 - 2) @(posedge clk);
			end else begin
				repeat (BIT_CLKS) @(posedge clk);
			end
		end
		line <= 1'b1;
		repeat (BIT_CLKS) @(posedge clk);
	endtask : send
endmodule : sre_tx
`default_nettype wire

// ==== tb/sre_receive_error_flags_test.sv ====
// Self-checking bench of the receive error flag block
`timescale 1ns/1ps
`default_nettype none
module sre_receive_error_flags_test;
	import sre_pkg::*;
	localparam int BIT_CLKS = 16 * RST_BAUD;
	logic              SYS_CLK = 1'b0;
	logic              RESETN = 1'b0;
	logic [ADDR_W-1:0] ADDR = '0;
	logic [DATA_W-1:0] WDATA = '0;
	logic              WR = 1'b0;
	logic              RD = 1'b0;
	logic              BIT_ERROR_EVENT = 1'b0;
	wire logic [7:0]   RDATA;
	wire logic         RX_PIN;
	wire logic         IRQ;
	int                mismatches = 0;
	int                n_compared = 0;
	always #4 SYS_CLK = ~SYS_CLK;
	sre_receive_error_flags sre_receive_error_flags_i (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RX_PIN(RX_PIN),
		.BIT_ERROR_EVENT(BIT_ERROR_EVENT), .IRQ(IRQ));
	sre_tx #(.BIT_CLKS(BIT_CLKS)) sre_tx_i (.clk(SYS_CLK), .line(RX_PIN));
	// ==========================================
	// Shared tasks
	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected register value at %0t: %h, wanted %h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_irq(input logic exp);
		@(negedge SYS_CLK);
		n_compared++;
		if (IRQ !== exp) begin
			mismatches++;
			$display("unexpected interrupt at %0t: %h, wanted %h", $time, IRQ, exp);
		end
		@(posedge SYS_CLK);
	endtask : chk_irq
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge SYS_CLK);
		WR <= 1'b0;
		@(posedge SYS_CLK);
	endtask : wr
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge SYS_CLK);
		RD <= 1'b0;
		@(negedge SYS_CLK);
		chk_reg(RDATA, exp);
		@(posedge SYS_CLK);
	endtask : rd_chk
	task automatic rx(input logic [9:0] bits, input int n, input logic glitch);
		sre_tx_i.send(bits, n, glitch);
		repeat (BIT_CLKS) @(posedge SYS_CLK);
	endtask : rx
	task automatic pulse_bit_error();
		BIT_ERROR_EVENT <= 1'b1;
		@(posedge SYS_CLK);
		BIT_ERROR_EVENT <= 1'b0;
		repeat (2) @(posedge SYS_CLK);
	endtask : pulse_bit_error
	// ==========================================
	// Scenarios
	task automatic t_reset();
		chk_irq(1'b0);
		rd_chk(OFF_RX_STATUS, 8'h00);
		wr(OFF_MAP_CONTROL, 8'h80);
		rd_chk(OFF_ALT_CONTROL, 8'h00);
		wr(OFF_ALT_CONTROL, 8'hff);
		rd_chk(OFF_ALT_CONTROL, 8'h83);
		wr(OFF_ALT_CONTROL, 8'h00);
		wr(OFF_MAP_CONTROL, 8'h00);
		rd_chk(OFF_BAUD_LOW, RST_BAUD[7:0]);
		rd_chk(3'h3, 8'h00);
		rd_chk(3'h6, 8'h00);
	endtask : t_reset
	task automatic t_frame();
		wr(OFF_CONTROL, 8'h04);
		rd_chk(OFF_CONTROL, 8'h04);
		rx({2'b01, 8'ha5}, 9, 1'b0);
		rd_chk(OFF_RX_STATUS, 8'h20);
		rd_chk(OFF_RX_DATA_LOW, 8'ha5);
		rd_chk(OFF_RX_STATUS, 8'h00);
	endtask : t_frame
	task automatic t_overrun();
		rx({2'b01, 8'h11}, 9, 1'b0);
		rd_chk(OFF_RX_STATUS, 8'h20);
		rx({2'b01, 8'h22}, 9, 1'b0);
		rd_chk(OFF_RX_DATA_LOW, 8'h11);
		rd_chk(OFF_RX_STATUS, 8'h08);
		rd_chk(OFF_RX_DATA_LOW, 8'h11);
		rd_chk(OFF_RX_STATUS, 8'h00);
		rx({2'b01, 8'h33}, 9, 1'b0);
		rd_chk(OFF_RX_STATUS, 8'h20);
		rd_chk(OFF_RX_DATA_LOW, 8'h33);
	endtask : t_overrun
	task automatic t_framing();
		rx({2'b00, 8'h5a}, 9, 1'b0);
		rd_chk(OFF_RX_STATUS, 8'h22);
		rx({2'b01, 8'h66}, 9, 1'b0);
		rd_chk(OFF_RX_STATUS, 8'h22);
		rd_chk(OFF_RX_DATA_LOW, 8'h5a);
		rd_chk(OFF_RX_STATUS, 8'h00);
	endtask : t_framing
	task automatic t_parity_noise();
		for (int t = 0; t < 2; t++) begin
			wr(OFF_CONTROL, 8'h06 | 8'(t));
			rx({2'b10, 8'h01}, 10, 1'b0);
			rd_chk(OFF_RX_STATUS, (t == 0) ? 8'h21 : 8'h20);
			rd_chk(OFF_RX_DATA_LOW, 8'h01);
		end
		wr(OFF_CONTROL, 8'h04);
		rx({2'b01, 8'h3c}, 9, 1'b1);
		rd_chk(OFF_RX_STATUS, 8'h24);
		rd_chk(OFF_RX_DATA_LOW, 8'h3c);
		rd_chk(OFF_RX_STATUS, 8'h00);
	endtask : t_parity_noise
	task automatic t_irq();
		wr(OFF_MAP_CONTROL, 8'h80);
		rd_chk(OFF_IRQ_STATUS, 8'h80);
		pulse_bit_error();
		chk_irq(1'b0);
		rd_chk(OFF_IRQ_STATUS, 8'h02);
		wr(OFF_ALT_CONTROL, 8'h02);
		pulse_bit_error();
		chk_irq(1'b1);
		rd_chk(OFF_IRQ_STATUS, 8'h02);
		repeat (2) @(posedge SYS_CLK);
		chk_irq(1'b0);
		wr(OFF_ALT_CONTROL, 8'h80);
		rx({2'b01, 8'h55}, 9, 1'b0);
		chk_irq(1'b1);
		rd_chk(OFF_IRQ_STATUS, 8'h80);
		rd_chk(OFF_RX_STATUS, 8'h20);
		rd_chk(OFF_RX_DATA_LOW, 8'h55);
		wr(OFF_ALT_CONTROL, 8'h01);
		rx({2'b00, 8'h00}, 9, 1'b0);
		chk_irq(1'b1);
		rd_chk(OFF_IRQ_STATUS, 8'h81);
		rd_chk(OFF_RX_STATUS, 8'h22);
		rd_chk(OFF_RX_DATA_LOW, 8'h00);
		chk_irq(1'b0);
	endtask : t_irq
	// Reset in mid-run with full and framing flags, all enables and interrupt set
	task automatic t_mid_reset();
		wr(OFF_MAP_CONTROL, 8'h80);
		wr(OFF_ALT_CONTROL, 8'h83);
		pulse_bit_error();
		chk_irq(1'b1);
		rx({2'b00, 8'h5a}, 9, 1'b0);
		rd_chk(OFF_RX_STATUS, 8'h22);
		RESETN <= 1'b0;
		repeat (4) @(posedge SYS_CLK);
		RESETN <= 1'b1;
		@(posedge SYS_CLK);
		chk_irq(1'b0);
		rd_chk(OFF_RX_STATUS, 8'h00);
		rd_chk(OFF_MAP_CONTROL, 8'h00);
		wr(OFF_MAP_CONTROL, 8'h80);
		rd_chk(OFF_ALT_CONTROL, 8'h00);
		rd_chk(OFF_IRQ_STATUS, 8'h00);
	endtask : t_mid_reset
	initial begin
		repeat (16) @(posedge SYS_CLK);
		RESETN <= 1'b1;
		@(posedge SYS_CLK);
		t_reset();
		t_frame();
		t_overrun();
		t_framing();
		t_parity_noise();
		t_irq();
		t_mid_reset();
		print_verdict();
	end
	initial begin
		repeat (40000) @(posedge SYS_CLK);
		mismatches++;
		print_verdict();
	end
endmodule : sre_receive_error_flags_test
`default_nettype wire
